// *** src/wwd_top.sv ***
`timescale 1ns/1ps
module wwd_top
  import wwd_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [WWD_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [WWD_DAT_W-1:0] wb_dat_i,
  output logic [WWD_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // core side
  input wire logic bitop_i,
  input wire logic sleep_i,
  input wire logic lockup_i,
  input wire logic [7:0] option_i,
  // slow oscillator, raw pin
  input wire logic slow_osc_clock_i,
  // results
  output logic interval_interrupt_o,
  output logic wdt_reset_req_o,
  output logic watchdog_reset_flag_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic opt_valid;
    wwd_opt_s opt;
    wwd_cnt_t cnt;
    logic running;
    logic first_done;
    logic irq_done;
    logic irq;
    logic hang_en;
    logic guard_en;
    logic hang_mode;
    logic sleep_q;
    logic rst_req;
    logic flag;
    logic ack;
    logic [WWD_DAT_W-1:0] rdata;
  } wwd_state_s;

  wwd_state_s q;
  wwd_state_s next_q;

  logic slow_tick;
  wwd_cnt_t ovf_cnt;
  wwd_cnt_t close_cnt;
  wwd_cnt_t irq_cnt;
  logic [2:0] eff_sel;

  // ----------------------------------------
  // slow clock edge detect
  // ----------------------------------------
  wwd_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(slow_osc_clock_i),
    .rise_o(slow_tick)
  );

  assign eff_sel = q.hang_mode ? WWD_HANG_OVF_SEL : q.opt.ovf_sel;

  wwd_limits u_limits (
    .ovf_sel_i(eff_sel),
    .ovf_cnt_o(ovf_cnt),
    .close_cnt_o(close_cnt),
    .irq_cnt_o(irq_cnt)
  );

  // ----------------------------------------
  // register decode helpers
  // ----------------------------------------
  function automatic logic hit(input logic [WWD_ADR_W-1:0] adr, input logic [31:0] idx);
    return adr[WWD_ADR_W-1:2] == idx;
  endfunction : hit

  logic req;
  logic wr;
  logic wr_byte;
  logic [7:0] wbyte;
  logic win_open;
  logic halted;
  logic [7:0] cause_byte;

  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~q.ack;
    wr = req & wb_we_i;
    wr_byte = wr & wb_sel_i[0];
    wbyte = wb_dat_i[7:0];
    // window open test
    win_open = 1'b1;
    if (q.opt.sleep_run && q.opt.window == WWD_WIN_75 && !q.hang_mode) begin
      win_open = q.cnt >= close_cnt;
    end
    halted = sleep_i & ~q.opt.sleep_run;
    cause_byte = 8'h00;
    cause_byte[WWD_CAUSE_FLAG_BIT] = q.flag;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_q = q;
    if (ce_i) begin
      next_q.irq = 1'b0;
      next_q.ack = req;
      next_q.sleep_q = sleep_i;

      // option byte capture at release
      if (!q.opt_valid) begin
        next_q.opt_valid = 1'b1;
        next_q.opt = option_i;
        next_q.running = option_i[WWD_OPT_RUN_BIT];
      end

      // counting
      if (q.running && !halted && slow_tick) begin
        if (q.cnt + WWD_CNT_ONE >= ovf_cnt) begin
          next_q.rst_req = 1'b1;
        end
        next_q.cnt = q.cnt + WWD_CNT_ONE;
        if (q.opt.irq_en && !q.irq_done && q.cnt + WWD_CNT_ONE == irq_cnt) begin
          next_q.irq = 1'b1;
          next_q.irq_done = 1'b1;
        end
      end

      // wake from sleep without sleep-run
      if (q.sleep_q && !sleep_i && !q.opt.sleep_run) begin
        next_q.cnt = WWD_CNT_ZERO;
        next_q.irq_done = 1'b0;
      end

      // lockup start
      if (lockup_i && q.hang_en && !q.hang_mode) begin
        next_q.hang_mode = 1'b1;
        next_q.running = 1'b1;
        next_q.cnt = WWD_CNT_ZERO;
      end

      // register reads
      next_q.rdata = '0;
      if (req && !wb_we_i) begin
        if (hit(wb_adr_i, WWD_IDX_SERVICE)) begin
          next_q.rdata[7:0] = q.opt.run ? WWD_SERVICE_RD_RUN : WWD_SERVICE_RD_STOP;
        end else if (hit(wb_adr_i, WWD_IDX_HANG_CTRL)) begin
          next_q.rdata[0] = q.hang_en;
        end else if (hit(wb_adr_i, WWD_IDX_HANG_GUARD)) begin
          next_q.rdata[0] = q.guard_en;
        end else if (hit(wb_adr_i, WWD_IDX_RESET_CAUSE)) begin
          next_q.rdata[7:0] = cause_byte;
        end
      end

      // register writes
      if (wr) begin
        if (hit(wb_adr_i, WWD_IDX_SERVICE)) begin
          if (bitop_i) begin
            next_q.rst_req = 1'b1;
          end else if (wr_byte && wbyte != WWD_SERVICE_KEY) begin
            next_q.rst_req = 1'b1;
          end else if (wr_byte && q.first_done && !win_open) begin
            next_q.rst_req = 1'b1;
          end else if (wr_byte) begin
            next_q.cnt = WWD_CNT_ZERO;
            next_q.first_done = 1'b1;
            next_q.irq_done = 1'b0;
          end
        end else if (hit(wb_adr_i, WWD_IDX_HANG_CTRL)) begin
          if (wr_byte && q.guard_en) begin
            next_q.hang_en = wbyte[0];
          end
        end else if (hit(wb_adr_i, WWD_IDX_HANG_GUARD)) begin
          if (wr_byte && wbyte[7:1] == WWD_GUARD_KEY) begin
            next_q.guard_en = wbyte[0];
          end
        end else if (hit(wb_adr_i, WWD_IDX_RESET_CAUSE)) begin
          if (wr_byte && wbyte[WWD_CAUSE_FLAG_BIT]) begin
            next_q.flag = 1'b0;
          end
        end
      end

      // a new reset request sets the flag, set wins over clear
      if (next_q.rst_req && !q.rst_req) begin
        next_q.flag = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.hang_en <= WWD_HANG_CTRL_RST[0];
      q.guard_en <= WWD_HANG_GUARD_RST[0];
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;
  assign interval_interrupt_o = q.irq;
  assign wdt_reset_req_o = q.rst_req;
  assign watchdog_reset_flag_o = q.flag;

endmodule : wwd_top

// *** src/wwd_pkg.sv ***
package wwd_pkg;

  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int WWD_ADR_W = 34;
  localparam int WWD_DAT_W = 32;

  // register indices, byte address is four times the index
  localparam logic [31:0] WWD_IDX_HANG_CTRL = 32'h40020405;
  localparam logic [31:0] WWD_IDX_HANG_GUARD = 32'h40020406;
  localparam logic [31:0] WWD_IDX_SERVICE = 32'h40021001;
  localparam logic [31:0] WWD_IDX_RESET_CAUSE = 32'h40021002;

  // ----------------------------------------
  // values and keys
  // ----------------------------------------
  localparam logic [7:0] WWD_SERVICE_KEY = 8'hac;
  localparam logic [7:0] WWD_SERVICE_RD_RUN = 8'h9a;
  localparam logic [7:0] WWD_SERVICE_RD_STOP = 8'h1a;
  localparam logic [6:0] WWD_GUARD_KEY = 7'h78;
  localparam logic [7:0] WWD_HANG_CTRL_RST = 8'h00;
  localparam logic [7:0] WWD_HANG_GUARD_RST = 8'h00;
  localparam logic [2:0] WWD_HANG_OVF_SEL = 3'b010;

  // ----------------------------------------
  // option byte fields, reset cause flag bit
  // ----------------------------------------
  localparam int WWD_OPT_IRQ_BIT = 7;
  localparam int WWD_OPT_WIN_HI = 6;
  localparam int WWD_OPT_WIN_LO = 5;
  localparam int WWD_OPT_RUN_BIT = 4;
  localparam int WWD_OPT_OVF_HI = 3;
  localparam int WWD_OPT_OVF_LO = 1;
  localparam int WWD_OPT_SLEEP_BIT = 0;
  localparam int WWD_CAUSE_FLAG_BIT = 4;
  localparam logic [1:0] WWD_WIN_75 = 2'b10;

  // ----------------------------------------
  // counter
  // ----------------------------------------
  localparam int WWD_CNT_W = 17;
  localparam logic [16:0] WWD_CNT_ZERO = 17'h00000;
  localparam logic [16:0] WWD_CNT_ONE = 17'h00001;

  typedef logic [16:0] wwd_cnt_t;

  // overflow exponent per select code
  function automatic logic [4:0] wwd_ovf_exp(input logic [2:0] sel);
    logic [4:0] e;
    e = 5'd6;
    case (sel)
      3'b000: e = 5'd6;
      3'b001: e = 5'd7;
      3'b010: e = 5'd8;
      3'b011: e = 5'd9;
      3'b100: e = 5'd11;
      3'b101: e = 5'd13;
      3'b110: e = 5'd14;
      default: e = 5'd16;
    endcase
    return e;
  endfunction : wwd_ovf_exp

  typedef struct packed {
    logic irq_en;
    logic [1:0] window;
    logic run;
    logic [2:0] ovf_sel;
    logic sleep_run;
  } wwd_opt_s;

endpackage : wwd_pkg

// *** src/wwd_sync.sv ***
`timescale 1ns/1ps
module wwd_sync
  import wwd_pkg::*;
(
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // async level in
  input wire logic async_i,
  // rising edge out
  output logic rise_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } wwd_sync_s;

  wwd_sync_s q;
  wwd_sync_s next_q;

  always_comb begin
    next_q = q;
    if (ce_i) begin
      next_q.s1 = async_i;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rise_o = q.s2 & ~q.s3;

endmodule : wwd_sync

// *** src/wwd_limits.sv ***
`timescale 1ns/1ps
module wwd_limits
  import wwd_pkg::*;
(
  // select
  input wire logic [2:0] ovf_sel_i,
  // thresholds
  output wwd_cnt_t ovf_cnt_o,
  output wwd_cnt_t close_cnt_o,
  output wwd_cnt_t irq_cnt_o
);

  logic [4:0] e;

  always_comb begin
    e = wwd_ovf_exp(ovf_sel_i);
    ovf_cnt_o = WWD_CNT_ONE << e;
    close_cnt_o = ovf_cnt_o >> 2;
    irq_cnt_o = ovf_cnt_o - close_cnt_o;
  end

endmodule : wwd_limits

// *** verification/wwd_top_properties.sv ***
`timescale 1ns/1ps
module wwd_top_properties
  import wwd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [WWD_DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  // results
  input wire logic interval_interrupt_o,
  input wire logic wdt_reset_req_o,
  input wire logic watchdog_reset_flag_o
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_quiet;
    !wdt_reset_req_o && !interval_interrupt_o && !watchdog_reset_flag_o;
  endsequence
  chk_bus_answer: assert property (s_take |=> wb_ack_o)
    else $error("request not acked");
  chk_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside ack");
  chk_read_not_key: assert property (wb_ack_o |-> wb_dat_o[7:0] != WWD_SERVICE_KEY)
    else $error("key value read back");
  chk_req_held: assert property (wdt_reset_req_o |=> wdt_reset_req_o)
    else $error("reset request dropped");
  chk_flag_on_req: assert property ($rose(wdt_reset_req_o) |-> watchdog_reset_flag_o)
    else $error("cause flag missing");
  chk_irq_pulse: assert property (interval_interrupt_o && ce_i |=> !interval_interrupt_o)
    else $error("interrupt not a pulse");
  chk_quiet_release: assert property ($fell(rst_i) |-> s_quiet)
    else $error("outputs busy after reset");
endmodule : wwd_top_properties

bind wwd_top wwd_top_properties wwd_top_properties_i (.*);

// *** verification/test_wwd_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) check(32'(g), 32'(e))
module test_wwd_top;
  import wwd_pkg::*;
  typedef struct packed {
    logic [31:0] idx;
    logic we;
    logic [7:0] wd;
    logic [7:0] ex;
  } wwd_row_s;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic bitop_i = 1'b0, sleep_i = 1'b0, lockup_i = 1'b0, slow_osc_clock_i = 1'b0;
  logic [WWD_ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h1;
  logic [WWD_DAT_W-1:0] wb_dat_i = '0, wb_dat_o;
  logic [7:0] option_i = 8'hd1, rd;
  logic wb_ack_o, interval_interrupt_o, wdt_reset_req_o, watchdog_reset_flag_o;
  logic [2:0] div = 3'h0;
  int num_errors = 0, total_checks = 0, c;
  wwd_row_s rows [9] = '{
    '{WWD_IDX_SERVICE, 1'b0, 8'h00, 8'h9a},
    '{WWD_IDX_HANG_CTRL, 1'b0, 8'h00, 8'h00},
    '{WWD_IDX_HANG_GUARD, 1'b0, 8'h00, 8'h00},
    '{WWD_IDX_RESET_CAUSE, 1'b0, 8'h00, 8'h00},
    '{WWD_IDX_HANG_CTRL, 1'b1, 8'h01, 8'h00},
    '{WWD_IDX_HANG_GUARD, 1'b1, 8'h01, 8'h00},
    '{WWD_IDX_HANG_GUARD, 1'b1, 8'hf1, 8'h01},
    '{WWD_IDX_HANG_CTRL, 1'b1, 8'h01, 8'h01},
    '{32'h40020000, 1'b0, 8'h00, 8'h00}
  };

  wwd_top wwd_top_i (.*);

  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    div <= div + 3'h1;
    slow_osc_clock_i <= div[2];
  end

  task automatic print_verdict();
    $display("errors=%0d checks=%0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  task automatic bus(input logic [31:0] idx, input logic we, input logic [7:0] d);
    int k;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 20) begin
      num_errors++;
      print_verdict();
    end
    @(posedge clk_i);
  endtask : bus

  task automatic wait_for(input int lim, input logic req, output int n);
    n = 0;
    while ((req ? wdt_reset_req_o : interval_interrupt_o) !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) begin
      num_errors++;
      print_verdict();
    end
  endtask : wait_for

  task automatic do_reset(input logic [7:0] opt);
    rst_i <= 1'b1;
    option_i <= opt;
    lockup_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    do_reset(8'hd1);
    for (int i = 0; i < 9; i++) begin
      if (rows[i].we) bus(rows[i].idx, 1'b1, rows[i].wd);
      bus(rows[i].idx, 1'b0, 8'h00);
      `CHK(rd, rows[i].ex);
    end
    do_reset(8'hd1);
    bus(WWD_IDX_SERVICE, 1'b1, WWD_SERVICE_KEY);
    `CHK(wdt_reset_req_o, 1'b0);
    bus(WWD_IDX_SERVICE, 1'b1, WWD_SERVICE_KEY);
    `CHK(wdt_reset_req_o, 1'b1);
    bus(WWD_IDX_RESET_CAUSE, 1'b0, 8'h00);
    `CHK(rd, 8'h10);
    for (int i = 0; i < 2; i++) begin
      do_reset(8'hd1);
      bitop_i <= (i == 0);
      bus(WWD_IDX_SERVICE, 1'b1, i ? 8'h5a : WWD_SERVICE_KEY);
      bitop_i <= 1'b0;
      `CHK(wdt_reset_req_o, 1'b1);
    end
    do_reset(8'hd1);
    wait_for(450, 1'b0, c);
    `CHK(c > 370 && c < 400, 1'b1);
    wait_for(200, 1'b1, c);
    `CHK(c > 125 && c < 131, 1'b1);
    do_reset(8'hd1);
    bus(WWD_IDX_SERVICE, 1'b1, WWD_SERVICE_KEY);
    repeat (200) @(posedge clk_i);
    bus(WWD_IDX_SERVICE, 1'b1, WWD_SERVICE_KEY);
    repeat (450) @(posedge clk_i);
    bus(WWD_IDX_SERVICE, 1'b0, 8'h00);
    `CHK(rd, WWD_SERVICE_RD_RUN);
    `CHK(wdt_reset_req_o, 1'b0);
    do_reset(8'hc1);
    bus(WWD_IDX_SERVICE, 1'b0, 8'h00);
    `CHK(rd, WWD_SERVICE_RD_STOP);
    repeat (700) @(posedge clk_i);
    `CHK(wdt_reset_req_o, 1'b0);
    bus(WWD_IDX_HANG_GUARD, 1'b1, 8'hf1);
    bus(WWD_IDX_HANG_CTRL, 1'b1, 8'h01);
    lockup_i <= 1'b1;
    wait_for(2200, 1'b1, c);
    `CHK(c > 2030 && c < 2070, 1'b1);
    do_reset(8'hd0);
    sleep_i <= 1'b1;
    repeat (600) @(posedge clk_i);
    `CHK(wdt_reset_req_o, 1'b0);
    sleep_i <= 1'b0;
    bus(WWD_IDX_SERVICE, 1'b1, WWD_SERVICE_KEY);
    bus(WWD_IDX_SERVICE, 1'b1, WWD_SERVICE_KEY);
    `CHK(wdt_reset_req_o, 1'b0);
    wait_for(600, 1'b1, c);
    `CHK(c > 490 && c < 530, 1'b1);
    do_reset(8'hd1);
    ce_i <= 1'b0;
    repeat (600) @(posedge clk_i);
    `CHK(wdt_reset_req_o, 1'b0);
    ce_i <= 1'b1;
    wait_for(600, 1'b1, c);
    `CHK(c > 490 && c < 530, 1'b1);
    print_verdict();
  end
endmodule : test_wwd_top
